// ### hdl/ata_timing_consts.svh
// Register offsets, field positions, reset values and timing codes of the drive port
`ifndef ATA_TIMING_CONSTS_SVH
`define ATA_TIMING_CONSTS_SVH
`define OFS_DRIVE_ACCESS_TIMING 8'hdf
`define OFS_DATA_EDGE_RATE_CTRL 8'he5
`define OFS_STROBE_EDGE_RATE_CTRL 8'he6
`define RST_REG8 8'h00
`define BIT_FAST_SEL 0
`define BIT_RDY_EN 1
`define BIT_PREFETCH 2
`define BIT_DMA_ONLY 3
`define FLD_RECOV_LO 4
`define FLD_DELAY_LO 6
`define STROBE_RW_MASK 8'h03
`define RST_STROBE_RATE 2'h0
`define FLD_STROBE_LO 0
`define FLD_NIB0_LO 0
`define FLD_NIB1_LO 2
`define FLD_NIB2_LO 4
`define FLD_NIB3_LO 6
`define DELAY_BASE 3'h5
`define RECOV_BASE 3'h4
`define COMPAT8_ACTIVE 3'h6
`define COMPAT8_RECOV 3'h6
`define COMPAT16_ACTIVE 3'h5
`define COMPAT16_RECOV 3'h4
`endif

// ### hdl/ata_timing_pkg.sv
// Types shared by the drive port timing configuration block
package ata_timing_pkg;
  typedef enum logic [1:0] {TIM_COMPAT8, TIM_COMPAT16, TIM_FAST} timing_class_t;
  typedef enum {ST_IDLE, ST_ACTIVE, ST_RECOVER} cyc_state_t;
endpackage : ata_timing_pkg

// ### hdl/ata_cycle_if.sv
// Interface between the register bank and the strobe sequencer
`timescale 1ns/10ps
`default_nettype none
interface ata_cycle_if;
  import ata_timing_pkg::*;
  logic start;
  logic is_data_port;
  logic is_dma;
  logic [1:0] delay_code;
  logic [1:0] recov_code;
  logic rdy_en;
  logic fast_sel;
  logic dma_only;
  logic drive_ready;
  logic strobe;
  logic busy;
  logic done;
  logic [1:0] klass;
  modport bank (output start, is_data_port, is_dma, delay_code, recov_code, rdy_en, fast_sel,
    dma_only, drive_ready, input strobe, busy, done, klass);
  modport seq (input start, is_data_port, is_dma, delay_code, recov_code, rdy_en, fast_sel,
    dma_only, drive_ready, output strobe, busy, done, klass);
endinterface : ata_cycle_if
`default_nettype wire

// ### hdl/ata_strobe_seq.sv
// Strobe sequencer: active width, ready sampling and recovery per access
`timescale 1ns/10ps
`default_nettype none
`include "ata_timing_consts.svh"
module ata_strobe_seq
  import ata_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  ata_cycle_if.seq cyc
);
  typedef struct packed {
    cyc_state_t st;
    logic [2:0] cnt;
    logic [2:0] recov;
    logic [1:0] klass;
  } seq_state_t;
  seq_state_t q_r, q_nxt;
  logic rdy_int;
  timing_class_t cls;

  // Forced ready when sampling is off real line otherwise
  assign rdy_int = cyc.rdy_en ? cyc.drive_ready : 1'b1;

  // Class of the access
  always_comb begin
    if (!cyc.is_data_port) begin
      cls = TIM_COMPAT8;
    end else if (!cyc.fast_sel) begin
      cls = TIM_COMPAT16;
    end else if (cyc.is_dma || !cyc.dma_only) begin
      cls = TIM_FAST;
    end else begin
      cls = TIM_COMPAT16;
    end
  end

  // Next state
  always_comb begin
    q_nxt = q_r;
    unique case (q_r.st)
      ST_IDLE: begin
        if (cyc.start) begin
          q_nxt.st = ST_ACTIVE;
          q_nxt.klass = cls;
          unique case (cls)
            TIM_FAST: begin
              q_nxt.cnt = `DELAY_BASE - {1'b0, cyc.delay_code};
              q_nxt.recov = `RECOV_BASE - {1'b0, cyc.recov_code};
            end
            TIM_COMPAT16: begin
              q_nxt.cnt = `COMPAT16_ACTIVE;
              q_nxt.recov = `COMPAT16_RECOV;
            end
            default: begin
              q_nxt.cnt = `COMPAT8_ACTIVE;
              q_nxt.recov = `COMPAT8_RECOV;
            end
          endcase
        end
      end
      ST_ACTIVE: begin
        if (q_r.cnt > 3'h1) begin
          q_nxt.cnt = q_r.cnt - 3'h1;
        end else if (rdy_int) begin // Stretch while drive not ready
          q_nxt.st = ST_RECOVER;
          q_nxt.cnt = q_r.recov;
        end
      end
      ST_RECOVER: begin
        if (q_r.cnt > 3'h1) begin
          q_nxt.cnt = q_r.cnt - 3'h1;
        end else begin
          q_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_r <= '{st: ST_IDLE, cnt: 3'h0, recov: 3'h0, klass: 2'h0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cyc.strobe = (q_r.st == ST_ACTIVE);
  assign cyc.busy = (q_r.st != ST_IDLE);
  assign cyc.done = (q_r.st == ST_RECOVER) && (q_nxt.st == ST_IDLE);
  assign cyc.klass = q_r.klass;
endmodule : ata_strobe_seq
`default_nettype wire

// ### hdl/ata_port_timing_cfg.sv
// Drive port timing and pad edge-rate register bank
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ata_timing_consts.svh"
module ata_port_timing_cfg
  import ata_timing_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic ACC_REQ,
  input wire logic ACC_DATA_PORT,
  input wire logic ACC_DMA,
  input wire logic ACC_WRITE,
  output logic ACC_BUSY,
  output logic ACC_DONE,
  output logic DRIVE_STROBE_B,
  output logic [1:0] TIMING_CLASS,
  output logic PREFETCH_ACTIVE,
  output logic POST_ACTIVE,
  input wire logic DRIVE_READY_LINE,
  output logic [1:0] NIBBLE3_EDGE_RATE,
  output logic [1:0] NIBBLE2_EDGE_RATE,
  output logic [1:0] NIBBLE1_EDGE_RATE,
  output logic [1:0] NIBBLE0_EDGE_RATE,
  output logic [1:0] STROBE_EDGE_RATE
);
  typedef struct packed {
    logic [7:0] timing;
    logic [7:0] data_rate;
    logic [1:0] strobe_rate;
    logic [7:0] rdata;
    logic [2:0] rdy_sync;
    logic rdy_filt;
  } bank_state_t;
  bank_state_t s_r, s_nxt;
  ata_cycle_if cyc ();

  // Register select helper used for writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Register writes, read capture and ready pin synchroniser
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdy_sync = {s_r.rdy_sync[1:0], DRIVE_READY_LINE};
    // Ready changes only once sync stages two and three agree
    if (s_r.rdy_sync[1] == s_r.rdy_sync[2]) begin
      s_nxt.rdy_filt = s_r.rdy_sync[2];
    end
    if (WR && hit(ADDR, `OFS_DRIVE_ACCESS_TIMING)) begin
      s_nxt.timing = WDATA;
    end
    if (WR && hit(ADDR, `OFS_DATA_EDGE_RATE_CTRL)) begin
      s_nxt.data_rate = WDATA;
    end
    if (WR && hit(ADDR, `OFS_STROBE_EDGE_RATE_CTRL)) begin
      s_nxt.strobe_rate = WDATA[`FLD_STROBE_LO +: 2];
    end
    s_nxt.rdata = 8'h00;
    if (RD) begin
      if (hit(ADDR, `OFS_DRIVE_ACCESS_TIMING)) begin
        s_nxt.rdata = s_r.timing;
      end else if (hit(ADDR, `OFS_DATA_EDGE_RATE_CTRL)) begin
        s_nxt.rdata = s_r.data_rate;
      end else if (hit(ADDR, `OFS_STROBE_EDGE_RATE_CTRL)) begin
        s_nxt.rdata = {6'h00, s_r.strobe_rate} & `STROBE_RW_MASK;
      end
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s_r <= '{timing: `RST_REG8, data_rate: `RST_REG8, strobe_rate: `RST_STROBE_RATE,
               rdata: `RST_REG8, rdy_sync: 3'h0, rdy_filt: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Field fan-out to the sequencer
  assign cyc.start = ACC_REQ;
  assign cyc.is_data_port = ACC_DATA_PORT;
  assign cyc.is_dma = ACC_DMA;
  assign cyc.delay_code = s_r.timing[`FLD_DELAY_LO +: 2];
  assign cyc.recov_code = s_r.timing[`FLD_RECOV_LO +: 2];
  assign cyc.rdy_en = s_r.timing[`BIT_RDY_EN];
  assign cyc.fast_sel = s_r.timing[`BIT_FAST_SEL];
  assign cyc.dma_only = s_r.timing[`BIT_DMA_ONLY];
  assign cyc.drive_ready = s_r.rdy_filt;

  ata_strobe_seq u_seq (
    .clk(CLOCK),
    .rst_b(RST_B),
    .cyc(cyc)
  );

  // Prefetch for reads and posting for writes on data port only
  assign PREFETCH_ACTIVE = s_r.timing[`BIT_PREFETCH] && ACC_DATA_PORT && !ACC_WRITE;
  assign POST_ACTIVE = s_r.timing[`BIT_PREFETCH] && ACC_DATA_PORT && ACC_WRITE;

  // Pad controls, 11 fastest and 00 slowest
  assign NIBBLE3_EDGE_RATE = s_r.data_rate[`FLD_NIB3_LO +: 2];
  assign NIBBLE2_EDGE_RATE = s_r.data_rate[`FLD_NIB2_LO +: 2];
  assign NIBBLE1_EDGE_RATE = s_r.data_rate[`FLD_NIB1_LO +: 2];
  assign NIBBLE0_EDGE_RATE = s_r.data_rate[`FLD_NIB0_LO +: 2];
  assign STROBE_EDGE_RATE = s_r.strobe_rate;

  assign RDATA = s_r.rdata;
  assign ACC_BUSY = cyc.busy;
  assign ACC_DONE = cyc.done;
  assign DRIVE_STROBE_B = ~cyc.strobe;
  assign TIMING_CLASS = cyc.klass;
endmodule : ata_port_timing_cfg
`default_nettype wire

// ### bench/ata_drive_model.sv
// Behavioural drive that holds its ready line low for a set number of strobe clocks
`timescale 1ns/10ps
`default_nettype none
module ata_drive_model (
  input wire logic clk,
  input wire logic strobe_b,
  input wire logic [3:0] stall,
  output logic ready
);
  logic [3:0] cnt_r = 4'h0;
  // Reload while idle, count down while the strobe is active
  always_ff @(posedge clk) begin
    cnt_r <= strobe_b ? stall : cnt_r - {3'h0, cnt_r != 4'h0};
  end
  assign ready = (cnt_r == 4'h0);
endmodule : ata_drive_model
`default_nettype wire

// ### bench/ata_port_timing_assertions.sv
// Checker for register mapping and strobe sequencing of the drive port bank
`timescale 1ns/10ps
`default_nettype none
module ata_port_timing_chk (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic ACC_REQ,
  input wire logic ACC_DATA_PORT,
  input wire logic ACC_WRITE,
  input wire logic ACC_BUSY,
  input wire logic ACC_DONE,
  input wire logic DRIVE_STROBE_B,
  input wire logic [1:0] TIMING_CLASS,
  input wire logic PREFETCH_ACTIVE,
  input wire logic [1:0] NIBBLE3_EDGE_RATE,
  input wire logic [1:0] STROBE_EDGE_RATE
);
  logic [7:0] wd_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Write data of the previous cycle, for checking the pad controls
  always_ff @(posedge CLOCK) begin
    wd_r <= WDATA;
  end
  // Prefetch enable as last written over the bus
  logic pref_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      pref_r <= 1'b0;
    end else if (WR && ADDR == 8'hdf) begin
      pref_r <= WDATA[2];
    end
  end
  sequence s_go;
    ACC_REQ && !ACC_BUSY;
  endsequence
  sequence s_act6;
    !DRIVE_STROBE_B [*6];
  endsequence
  a_rsv_zero: assert property (RD && ADDR == 8'he6 |=> RDATA[7:2] == 6'h00)
    else $error("strobe reg upper bits set");
  a_nib_map: assert property (WR && ADDR == 8'he5 |=> NIBBLE3_EDGE_RATE == wd_r[7:6])
    else $error("nibble control mismatch");
  a_stb_map: assert property (WR && ADDR == 8'he6 |=> STROBE_EDGE_RATE == wd_r[1:0])
    else $error("strobe control mismatch");
  a_pref_read: assert property (PREFETCH_ACTIVE == (pref_r && ACC_DATA_PORT && !ACC_WRITE))
    else $error("prefetch outside data read");
  a_nondata_compat: assert property (s_go ##0 !ACC_DATA_PORT |=> TIMING_CLASS == 2'h0 ##0 s_act6)
    else $error("non-data access not compat8");
  a_strobe_min: assert property (s_go |=> !DRIVE_STROBE_B [*2])
    else $error("strobe too short");
  a_done_rec: assert property ($rose(DRIVE_STROBE_B) |-> ##[0:5] ACC_DONE)
    else $error("recovery too long");
  a_done_idle: assert property (ACC_DONE |-> DRIVE_STROBE_B ##1 !ACC_BUSY)
    else $error("done not at end");
endmodule : ata_port_timing_chk
bind ata_port_timing_cfg ata_port_timing_chk i_chk (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .ACC_REQ, .ACC_DATA_PORT, .ACC_WRITE, .ACC_BUSY, .ACC_DONE, .DRIVE_STROBE_B,
  .TIMING_CLASS, .PREFETCH_ACTIVE, .NIBBLE3_EDGE_RATE, .STROBE_EDGE_RATE);
`default_nettype wire

// ### bench/ata_port_timing_cfg_tb_top.sv
// Self-checking bench for the drive port timing bank
`timescale 1ns/10ps
`default_nettype none
module ata_port_timing_cfg_tb_top;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic ACC_REQ = 1'b0;
  logic ACC_DATA_PORT = 1'b0;
  logic ACC_DMA = 1'b0;
  logic ACC_WRITE = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  wire logic [7:0] nib;
  logic [1:0] ser;
  logic [1:0] TIMING_CLASS;
  logic ACC_BUSY, ACC_DONE, DRIVE_STROBE_B, PREFETCH_ACTIVE, POST_ACTIVE, DRIVE_READY_LINE;
  logic [3:0] stall = 4'h0;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  always #25 CLOCK = ~CLOCK;
  ata_port_timing_cfg i_dut (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .ACC_REQ,
    .ACC_DATA_PORT, .ACC_DMA, .ACC_WRITE, .ACC_BUSY, .ACC_DONE, .DRIVE_STROBE_B, .TIMING_CLASS,
    .PREFETCH_ACTIVE, .POST_ACTIVE, .DRIVE_READY_LINE, .NIBBLE3_EDGE_RATE(nib[7:6]),
    .NIBBLE2_EDGE_RATE(nib[5:4]), .NIBBLE1_EDGE_RATE(nib[3:2]), .NIBBLE0_EDGE_RATE(nib[1:0]),
    .STROBE_EDGE_RATE(ser));
  ata_drive_model i_drv (.clk(CLOCK), .strobe_b(DRIVE_STROBE_B), .stall, .ready(DRIVE_READY_LINE));
  task chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task wreg(input logic [7:0] a, d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, e);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    exp_q.push_back(e);
    @(posedge CLOCK);
    RD <= 1'b0;
  endtask : rreg
  // Read data monitor: oldest expectation against the answer cycle
  always @(posedge CLOCK) begin
    rd_d <= RD;
    if (rd_d) chk(RDATA === exp_q.pop_front(), "read data");
  end
  task acc(input logic [7:0] t, input logic dp, dma, wr, input logic [1:0] cls,
      input int amin, amax, rec);
    int a;
    int r;
    bit dn;
    wreg(8'hdf, t);
    @(posedge CLOCK);
    ACC_REQ <= 1'b1;
    ACC_DATA_PORT <= dp;
    ACC_DMA <= dma;
    ACC_WRITE <= wr;
    @(posedge CLOCK);
    ACC_REQ <= 1'b0;
    #1;
    chk(PREFETCH_ACTIVE === (t[2] & dp & !wr) && POST_ACTIVE === (t[2] & dp & wr), "pf");
    chk(TIMING_CLASS === cls, "class");
    chk(ACC_BUSY === 1'b1, "busy");
    a = 0;
    r = 0;
    while (DRIVE_STROBE_B === 1'b0 && a < 40) begin
      a++;
      @(posedge CLOCK);
      #1;
    end
    chk(a >= amin && a <= amax, "active width");
    do begin
      r++;
      dn = (ACC_DONE === 1'b1);
      @(posedge CLOCK);
      #1;
    end while (!dn && r < 40);
    chk(r == rec, "recovery");
    chk(ACC_BUSY === 1'b0, "idle");
  endtask : acc
  task test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    test_done();
  end
  // Main sequence
  initial begin
    logic [7:0] v;
    void'($urandom(32'h59a8784d));
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    rreg(8'hdf, 8'h00);
    rreg(8'he5, 8'h00);
    rreg(8'he6, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wreg(8'he5, v);
      #1 chk(nib === v, "data edge");
      wreg(8'he6, v);
      #1 chk(ser === v[1:0], "strobe edge");
      rreg(8'he5, v);
      rreg(8'he6, v & 8'h03);
      wreg(8'h42, v);
      rreg(8'h42, 8'h00);
    end
    acc(8'h35, 1, 0, 0, 2, 5, 5, 1);
    acc(8'h77, 1, 0, 1, 2, 4, 4, 1);
    acc(8'hb1, 1, 0, 0, 2, 3, 3, 1);
    acc(8'hc1, 1, 0, 0, 2, 2, 2, 4);
    acc(8'h51, 1, 0, 0, 2, 4, 4, 3);
    acc(8'h00, 1, 1, 0, 1, 5, 5, 4);
    acc(8'ha1, 1, 1, 0, 2, 3, 3, 2);
    acc(8'hb9, 1, 1, 0, 2, 3, 3, 1);
    acc(8'h39, 1, 0, 0, 1, 5, 5, 4);
    acc(8'h31, 0, 0, 1, 0, 6, 6, 6);
    stall <= 4'ha;
    acc(8'h31, 1, 0, 0, 2, 5, 5, 1);
    acc(8'h33, 1, 0, 0, 2, 11, 20, 1);
    stall <= 4'h0;
    rreg(8'hdf, 8'h33);
    repeat (3) @(posedge CLOCK);
    test_done();
  end
endmodule : ata_port_timing_cfg_tb_top
`default_nettype wire
